//--- sstx_defines.svh
// Register offsets, field positions and reset values of the slave transmitter
`ifndef SSTX_DEFINES_SVH
`define SSTX_DEFINES_SVH

`define SSTX_ADDR_W         4
`define SSTX_OFF_INTCTL     4'h0
`define SSTX_OFF_FLAGS      4'h1
`define SSTX_OFF_ENABLES    4'h2
`define SSTX_OFF_PRIO       4'h3
`define SSTX_OFF_RXCTL      4'h4
`define SSTX_OFF_HOLD       4'h5
`define SSTX_OFF_TXCTL      4'h6
`define SSTX_OFF_RATECTL    4'h7
`define SSTX_OFF_DIVHI      4'h8
`define SSTX_OFF_DIVLO      4'h9
`define SSTX_OFF_IRQSTAT    4'ha
`define SSTX_OFF_IRQMASK    4'hb

`define SSTX_TX_CLOCK_SOURCE_SELECT        7
`define SSTX_TX_NINE        6
`define SSTX_TX_EN          5
`define SSTX_TX_SYNC        4
`define SSTX_TX_IDLE        1
`define SSTX_TX_D9          0
`define SSTX_RX_PORT_ENABLE_BIT        7
`define SSTX_RX_SINGLE_RECEIVE_ENABLE        5
`define SSTX_RX_CONTINUOUS_RECEIVE_ENABLE        4
`define SSTX_IC_GIE         7
`define SSTX_IC_PERIPHERAL_INTERRUPT_ENABLE        6
`define SSTX_PF_TXF         4
`define SSTX_IS_DONE        0
`define SSTX_IS_LOAD        1
`define SSTX_LAST_BIT8      4'd7
`define SSTX_LAST_BIT9      4'd8

`define SSTX_RST_TXCTL      8'h02
`define SSTX_RST_BYTE       8'h00
`define SSTX_RDATA_UNMAPPED 32'h0000_0000

`endif

//--- sstx_pkg.sv
// Types of the slave transmitter
package sstx_pkg;
    typedef enum logic [1:0] {
        SSTX_IDLE  = 2'b00,
        SSTX_SHIFT = 2'b01
    } sstx_state_t;
endpackage

//--- sstx_top.sv
// Synchronous slave serial transmitter with Avalon-MM register slave
// Function
// - Slave mode when clock source select cleared
// - Keeps shifting in any low-power state
// - Same as master transmit except sleep
// - First word moves to shifter at once
// - Second word held, empty flag stays clear
// - Reload second word, then set empty flag
// - Flag with enable wakes; global and peripheral enables interrupt
`timescale 1ns/1ps
`default_nettype none
`include "sstx_defines.svh"
module sstx_top (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Serial link
    input  wire logic        shift_clock_pin_i,
    output logic             data_out_o,
    output logic             data_oe_o,
    // Chip power and interrupts
    input  wire logic        sleep_i,
    output logic             wake_o,
    output logic             cpu_irq_o,
    output logic             irq_o
);
    import sstx_pkg::*;

    // Register state
    logic [7:0] intctl, enables, prio, rxctl, txctl, ratectl, divhi, divlo;
    logic [7:0] irq_stat, irq_mask;
    logic [7:0] next_intctl, next_enables, next_prio, next_rxctl, next_txctl;
    logic [7:0] next_ratectl, next_divhi, next_divlo, next_irq_stat, next_irq_mask;
    logic [8:0] hold, next_hold;
    logic       hold_full, next_hold_full;
    logic [31:0] rdata, next_rdata;
    logic        ack, next_ack;
    // Shifter state
    sstx_state_t state, next_state;
    logic [8:0]  transmit_shift_register, next_tsr;
    logic [3:0]  bit_cnt, next_bit_cnt;
    logic        dout, next_dout;
    // Link clock synchroniser
    logic [2:0]  ck_sync;
    logic        ck_level, next_ck_level;

    // Byte lane 0 write enables
    // A write acts only at the edge where waitrequest is low, i.e. while ack is up
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off);
        wr_hit = avs_write_i && avs_byteenable_i[0] && (a == off) && ack;
    endfunction

    logic port_on, slave_mode, tx_on, ck_fall, load_tsr, frame_done, txf;
    assign port_on    = rxctl[`SSTX_RX_PORT_ENABLE_BIT] && txctl[`SSTX_TX_SYNC];
    assign slave_mode = port_on && !txctl[`SSTX_TX_CLOCK_SOURCE_SELECT];
    assign tx_on      = slave_mode && txctl[`SSTX_TX_EN];
    // Shift on the external clock's falling edge, seen once two stages agree
    assign ck_fall    = ck_level && (ck_sync[2] == ck_sync[1]) && !ck_sync[2];
    assign frame_done = (state == SSTX_SHIFT) && ck_fall
                        && (bit_cnt == (txctl[`SSTX_TX_NINE] ? `SSTX_LAST_BIT9 : `SSTX_LAST_BIT8));
    // Holding word moves when the shifter is idle or just finished
    assign load_tsr   = tx_on && hold_full && ((state == SSTX_IDLE) || frame_done);
    // Empty flag is low while a word waits in the holding register
    assign txf        = !hold_full;

    // Pin synchroniser, three stages
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ck_sync <= 3'b111;
        end else begin
            ck_sync <= {ck_sync[1:0], shift_clock_pin_i};
        end
    end

    // Next state of the shifter; independent of sleep_i
    always_comb begin
        next_state    = state;
        next_tsr      = transmit_shift_register;
        next_bit_cnt  = bit_cnt;
        next_dout     = dout;
        next_ck_level = (ck_sync[2] == ck_sync[1]) ? ck_sync[2] : ck_level;
        if (!tx_on) begin
            next_state = SSTX_IDLE;
        end else if (load_tsr) begin
            next_state   = SSTX_SHIFT;
            next_tsr     = hold;
            next_bit_cnt = 4'd0;
            next_dout    = hold[0];
        end else if (frame_done) begin
            next_state = SSTX_IDLE;
        end else if ((state == SSTX_SHIFT) && ck_fall) begin
            next_tsr     = {1'b0, transmit_shift_register[8:1]};
            next_dout    = transmit_shift_register[1];
            next_bit_cnt = bit_cnt + 4'd1;
        end
    end

    // Shifter registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state    <= SSTX_IDLE;
            transmit_shift_register      <= 9'h000;
            bit_cnt  <= 4'h0;
            dout     <= 1'b1;
            ck_level <= 1'b1;
        end else begin
            state    <= next_state;
            transmit_shift_register      <= next_tsr;
            bit_cnt  <= next_bit_cnt;
            dout     <= next_dout;
            ck_level <= next_ck_level;
        end
    end

    // Register file next values
    always_comb begin
        next_intctl    = intctl;
        next_enables   = enables;
        next_prio      = prio;
        next_rxctl     = rxctl;
        next_txctl     = txctl;
        next_ratectl   = ratectl;
        next_divhi     = divhi;
        next_divlo     = divlo;
        next_irq_mask  = irq_mask;
        next_hold      = hold;
        next_hold_full = hold_full;
        next_irq_stat  = irq_stat;
        next_ack       = (avs_read_i || avs_write_i) && !ack;
        next_rdata     = rdata;
        if (load_tsr) begin
            next_hold_full = 1'b0;
        end
        if (wr_hit(avs_address_i, `SSTX_OFF_INTCTL))  next_intctl  = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_ENABLES)) next_enables = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_PRIO))    next_prio    = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_RXCTL))   next_rxctl   = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_RATECTL)) next_ratectl = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_DIVHI))   next_divhi   = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_DIVLO))   next_divlo   = avs_writedata_i[7:0];
        if (wr_hit(avs_address_i, `SSTX_OFF_IRQMASK)) next_irq_mask = avs_writedata_i[7:0];
        // Idle bit stays hardware owned
        if (wr_hit(avs_address_i, `SSTX_OFF_TXCTL)) begin
            next_txctl = {avs_writedata_i[7:2], txctl[1], avs_writedata_i[0]};
        end
        // Ninth bit comes from the control register at write time
        if (wr_hit(avs_address_i, `SSTX_OFF_HOLD) && !(hold_full && !load_tsr)) begin
            next_hold      = {txctl[`SSTX_TX_D9], avs_writedata_i[7:0]};
            next_hold_full = 1'b1;
        end
        next_txctl[`SSTX_TX_IDLE] = (next_state == SSTX_IDLE);
        // Write one to clear; a new event wins over the clear
        if (wr_hit(avs_address_i, `SSTX_OFF_IRQSTAT)) begin
            next_irq_stat = irq_stat & ~avs_writedata_i[7:0];
        end
        if (frame_done) next_irq_stat[`SSTX_IS_DONE] = 1'b1;
        if (load_tsr)   next_irq_stat[`SSTX_IS_LOAD] = 1'b1;
        if (avs_read_i && !ack) begin
            case (avs_address_i)
                `SSTX_OFF_INTCTL:  next_rdata = {24'h0, intctl};
                `SSTX_OFF_FLAGS:   next_rdata = {27'h0, txf, 4'h0};
                `SSTX_OFF_ENABLES: next_rdata = {24'h0, enables};
                `SSTX_OFF_PRIO:    next_rdata = {24'h0, prio};
                `SSTX_OFF_RXCTL:   next_rdata = {24'h0, rxctl};
                `SSTX_OFF_TXCTL:   next_rdata = {24'h0, txctl};
                `SSTX_OFF_RATECTL: next_rdata = {24'h0, ratectl};
                `SSTX_OFF_DIVHI:   next_rdata = {24'h0, divhi};
                `SSTX_OFF_DIVLO:   next_rdata = {24'h0, divlo};
                `SSTX_OFF_IRQSTAT: next_rdata = {24'h0, irq_stat};
                `SSTX_OFF_IRQMASK: next_rdata = {24'h0, irq_mask};
                default:           next_rdata = `SSTX_RDATA_UNMAPPED;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            intctl    <= `SSTX_RST_BYTE;
            enables   <= `SSTX_RST_BYTE;
            prio      <= `SSTX_RST_BYTE;
            rxctl     <= `SSTX_RST_BYTE;
            txctl     <= `SSTX_RST_TXCTL;
            ratectl   <= `SSTX_RST_BYTE;
            divhi     <= `SSTX_RST_BYTE;
            divlo     <= `SSTX_RST_BYTE;
            irq_stat  <= `SSTX_RST_BYTE;
            irq_mask  <= `SSTX_RST_BYTE;
            hold      <= 9'h000;
            hold_full <= 1'b0;
            rdata     <= 32'h0000_0000;
            ack       <= 1'b0;
        end else begin
            intctl    <= next_intctl;
            enables   <= next_enables;
            prio      <= next_prio;
            rxctl     <= next_rxctl;
            txctl     <= next_txctl;
            ratectl   <= next_ratectl;
            divhi     <= next_divhi;
            divlo     <= next_divlo;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            hold      <= next_hold;
            hold_full <= next_hold_full;
            rdata     <= next_rdata;
            ack       <= next_ack;
        end
    end

    // Outputs
    assign avs_readdata_o    = rdata;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign data_out_o        = dout;
    assign data_oe_o         = tx_on;
    assign wake_o            = txf && enables[`SSTX_PF_TXF] && tx_on;
    assign cpu_irq_o         = wake_o && intctl[`SSTX_IC_GIE] && intctl[`SSTX_IC_PERIPHERAL_INTERRUPT_ENABLE];
    assign irq_o             = |(irq_stat & irq_mask);

    // Checks
    property p_hold_drains;
        @(posedge clock_i) disable iff (sys_rst_i)
        (tx_on && hold_full && state == SSTX_IDLE && !wr_hit(avs_address_i, `SSTX_OFF_HOLD))
            |=> !hold_full && state == SSTX_SHIFT;
    endproperty
    a_hold_drains: assert property (p_hold_drains) else $error("holding word not taken");
    property p_flag_low_full;
        @(posedge clock_i) disable iff (sys_rst_i)
        (tx_on && hold_full && state == SSTX_SHIFT && !frame_done) |=> hold_full && !txf && !wake_o;
    endproperty
    a_flag_low_full: assert property (p_flag_low_full) else $error("empty flag while full");
    property p_reload;
        @(posedge clock_i) disable iff (sys_rst_i)
        (frame_done && hold_full && tx_on && !wr_hit(avs_address_i, `SSTX_OFF_HOLD))
            |=> state == SSTX_SHIFT && bit_cnt == 4'd0 && txf && data_out_o == $past(hold[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("second word not reloaded");
    property p_stable;
        @(posedge clock_i) disable iff (sys_rst_i)
        (!ck_fall && !load_tsr && tx_on) |=> $stable(data_out_o);
    endproperty
    a_stable: assert property (p_stable) else $error("output moved without clock");
    property p_cpu_irq;
        @(posedge clock_i) disable iff (sys_rst_i)
        cpu_irq_o |-> wake_o && intctl[`SSTX_IC_GIE] && intctl[`SSTX_IC_PERIPHERAL_INTERRUPT_ENABLE];
    endproperty
    a_cpu_irq: assert property (p_cpu_irq) else $error("interrupt without enables");
    property p_master_off;
        @(posedge clock_i) disable iff (sys_rst_i)
        txctl[`SSTX_TX_CLOCK_SOURCE_SELECT] |=> state == SSTX_IDLE;
    endproperty
    a_master_off: assert property (p_master_off) else $error("shifting outside slave mode");
    property p_sleep;
        @(posedge clock_i) disable iff (sys_rst_i)
        (sleep_i && tx_on && state == SSTX_SHIFT && ck_fall && !frame_done) |=> bit_cnt == $past(bit_cnt) + 4'd1;
    endproperty
    a_sleep: assert property (p_sleep) else $error("shift stalled in sleep");
    property p_ack;
        @(posedge clock_i) disable iff (sys_rst_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    property p_first_bit;
        @(posedge clock_i) disable iff (sys_rst_i)
        load_tsr |=> state == SSTX_SHIFT && bit_cnt == 4'd0 && data_out_o == $past(hold[0]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("word loaded without its first bit");
    property p_lsb_shift;
        @(posedge clock_i) disable iff (sys_rst_i)
        (tx_on && state == SSTX_SHIFT && ck_fall && !frame_done) |=> data_out_o == $past(transmit_shift_register[1]);
    endproperty
    a_lsb_shift: assert property (p_lsb_shift) else $error("next bit not shifted out");
    property p_frame_len;
        @(posedge clock_i) disable iff (sys_rst_i)
        state == SSTX_SHIFT |-> bit_cnt <= (txctl[`SSTX_TX_NINE] ? `SSTX_LAST_BIT9 : `SSTX_LAST_BIT8);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame longer than its word");
    // A write to a full holding register that is not draining is dropped
    property p_hold_refused;
        @(posedge clock_i) disable iff (sys_rst_i)
        (hold_full && !load_tsr) |=> hold == $past(hold);
    endproperty
    a_hold_refused: assert property (p_hold_refused) else $error("held word overwritten");
    property p_cut;
        @(posedge clock_i) disable iff (sys_rst_i)
        !tx_on |=> state == SSTX_IDLE;
    endproperty
    a_cut: assert property (p_cut) else $error("shifting while transmit is off");
    property p_write_edge;
        @(posedge clock_i) disable iff (sys_rst_i)
        (avs_write_i && avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_write_edge: assert property (p_write_edge) else $error("bus write answer late");
endmodule
`default_nettype wire

//--- sstx_master.sv
// External synchronous master that clocks words out of the slave transmitter
`timescale 1ns/1ps
`default_nettype none
module sstx_master (
    // Frame request from the bench
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [3:0] nbits_i,
    // Serial link
    input  wire logic       data_i,
    output logic            sck_o,
    // Captured frame
    output logic [8:0]      word_o,
    output logic            done_o
);
    // Clock idles high between frames, samples just before each fall
    // Period is 160 ns; slow_i only moves the phase against the system clock
    initial begin
        sck_o = 1'b1;
        word_o = 9'h000;
        done_o = 1'b0;
        forever begin
            @(posedge go_i);
            done_o = 1'b0;
            word_o = 9'h000;
            #(slow_i ? 13 : 3);
            for (int i = 0; i < nbits_i; i++) begin
                #80 word_o[i] = data_i;
                sck_o = 1'b0;
                #80 sck_o = 1'b1;
            end
            done_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- sstx_top_tb.sv
// Self-checking bench of the slave transmitter
`timescale 1ns/1ps
`default_nettype none
`include "sstx_defines.svh"
module sstx_top_tb;
    typedef struct {
        logic [7:0] ctl;
        logic [7:0] d;
        logic [3:0] nb;
        logic [8:0] w;
        logic       oe;
    } sstx_row_t;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        data_out_o;
    logic        data_oe_o;
    logic        sleep_i = 1'b0;
    logic        wake_o;
    logic        cpu_irq_o;
    logic        irq_o;
    logic        sck;
    logic        go = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  nb = 4'h8;
    logic [8:0]  word;
    logic        done;
    logic [31:0] q;
    int          n_errors = 0;
    int          n_tests = 0;
    sstx_row_t   rows [4];

    sstx_top uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'h1), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .shift_clock_pin_i(sck), .data_out_o(data_out_o), .data_oe_o(data_oe_o), .sleep_i(sleep_i),
        .wake_o(wake_o), .cpu_irq_o(cpu_irq_o), .irq_o(irq_o));
    sstx_master master (.go_i(go), .slow_i(slow), .nbits_i(nb), .data_i(data_out_o), .sck_o(sck),
        .word_o(word), .done_o(done));

    // System clock
    always #10 clock_i = ~clock_i;

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until the edge at which waitrequest is low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i     <= w;
        avs_read_i      <= !w;
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        // Let one edge pass with the strobes low
        @(posedge clock_i);
    endtask

    // Let the master clock one frame out
    task automatic frame(input logic [3:0] bits);
        int n;
        n = 0;
        nb <= bits;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 1000) n_errors++;
    endtask

    // Verdict
    task automatic end_sim;
        $display("Counts: %0d mismatches in %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #300_000;
        n_errors++;
        end_sim;
    end

    // Main sequence
    initial begin
        rows[0] = '{8'h30, 8'ha5, 4'h8, 9'h0a5, 1'b1};
        rows[1] = '{8'h71, 8'h3c, 4'h9, 9'h13c, 1'b1};
        rows[2] = '{8'h70, 8'hc3, 4'h9, 9'h0c3, 1'b1};
        rows[3] = '{8'hb0, 8'h00, 4'h8, 9'h000, 1'b0};
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        chk({data_out_o, data_oe_o, irq_o}, 3'b100);
        bus(1'b0, `SSTX_OFF_TXCTL, 8'h00);
        chk(q, {24'h0, `SSTX_RST_TXCTL});
        bus(1'b0, 4'hc, 8'h00);
        chk(q, `SSTX_RDATA_UNMAPPED);
        bus(1'b1, `SSTX_OFF_RXCTL, 8'h80);
        bus(1'b1, `SSTX_OFF_ENABLES, 8'h10);
        bus(1'b1, `SSTX_OFF_INTCTL, 8'hc0);
        bus(1'b1, `SSTX_OFF_IRQMASK, 8'h02);
        // Table of ordinary frames
        foreach (rows[i]) begin
            bus(1'b1, `SSTX_OFF_TXCTL, rows[i].ctl);
            chk(data_oe_o, rows[i].oe);
            if (rows[i].oe) begin
                bus(1'b1, `SSTX_OFF_HOLD, rows[i].d);
                slow <= i[0];
                frame(rows[i].nb);
                chk(word, rows[i].w);
                repeat (8) @(posedge clock_i);
                chk(wake_o, 1'b1);
            end
        end
        // Two words queued with the chip asleep
        bus(1'b1, `SSTX_OFF_TXCTL, 8'h30);
        bus(1'b1, `SSTX_OFF_IRQSTAT, 8'h03);
        sleep_i <= 1'b1;
        bus(1'b1, `SSTX_OFF_HOLD, 8'h5a);
        bus(1'b1, `SSTX_OFF_HOLD, 8'h96);
        bus(1'b0, `SSTX_OFF_FLAGS, 8'h00);
        chk({q[4], wake_o}, 2'b00);
        bus(1'b1, `SSTX_OFF_HOLD, 8'hff);
        frame(4'h8);
        chk(word, 9'h05a);
        repeat (8) @(posedge clock_i);
        bus(1'b0, `SSTX_OFF_FLAGS, 8'h00);
        chk(q[4], 1'b1);
        chk({wake_o, cpu_irq_o, irq_o}, 3'b111);
        frame(4'h8);
        chk(word, 9'h096);
        bus(1'b1, `SSTX_OFF_IRQSTAT, 8'h02);
        chk(irq_o, 1'b0);
        // Reset in mid-run returns pins and registers to their reset state
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        chk({data_out_o, data_oe_o, wake_o, irq_o}, 4'b1000);
        bus(1'b0, `SSTX_OFF_TXCTL, 8'h00);
        chk(q, {24'h0, `SSTX_RST_TXCTL});
        end_sim;
    end
endmodule
`default_nettype wire
